// *** logic/brs_pkg.sv ***
// Constants, register map and types for the four-rail buck supervisor.
// Assumes a 40 MHz system clock; all timings derive from CLK_NS.
package brs_pkg;
   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_NS = 25;
   localparam int US_NS = 1000;
   localparam int US_CYC = US_NS / CLK_NS;
   localparam int OV_FILT_NS = 2500;
   localparam int OV_FILT_CYC = (OV_FILT_NS + CLK_NS - 1) / CLK_NS;
   localparam int OV_REP_NS = 1000;
   localparam int OV_REP_CYC = (OV_REP_NS + CLK_NS - 1) / CLK_NS;
   localparam int EN_HOLD_NS = 4000;
   localparam int EN_HOLD_CYC = (EN_HOLD_NS + CLK_NS - 1) / CLK_NS;
   localparam int UV_FILT_US = 50;
   localparam int HIC_OFF_US = 1000;
   localparam logic [5:0] US_LAST = 6'(US_CYC - 1);
   localparam logic [6:0] OV_FILT_C = 7'(OV_FILT_CYC);
   localparam logic [6:0] OV_REP_C = 7'(OV_REP_CYC);
   localparam logic [7:0] EN_HOLD_C = 8'(EN_HOLD_CYC);
   localparam logic [15:0] UV_FILT_C = 16'(UV_FILT_US);
   localparam logic [15:0] HIC_OFF_C = 16'(HIC_OFF_US);

   // ----------------------------------------------------------------
   // Positions in the synchronised comparator vector
   // ----------------------------------------------------------------
   localparam int A_EN = 0;
   localparam int A_VOK = 1;
   localparam int A_HOT = 2;
   localparam int A_VOV = 3;
   localparam int G_BST = 4;
   localparam int G_RGF = 8;
   localparam int G_PG = 12;
   localparam int G_UV = 16;
   localparam int G_L87 = 20;
   localparam int G_OV = 24;
   localparam int G_L114 = 28;
   localparam int G_VOC = 32;
   localparam int G_NEG = 36;
   localparam int AW = 40;

   // ----------------------------------------------------------------
   // Register map (byte addresses) and fields
   // ----------------------------------------------------------------
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_PERIOD = 8'h04;
   localparam logic [7:0] A_PHASE = 8'h08;
   localparam logic [7:0] A_TARGET = 8'h0c;
   localparam logic [7:0] A_SS = 8'h10;
   localparam logic [7:0] A_PGDLY = 8'h14;
   localparam logic [7:0] A_STATUS = 8'h18;
   localparam int C_EN = 0;
   localparam int C_OVP = 4;
   localparam int C_DIS = 8;
   localparam int C_GPIO = 12;
   localparam int S_OVD = 0;
   localparam int S_PG = 4;
   localparam int S_RUN = 8;
   localparam int S_SYNC = 9;
   localparam int S_HOT = 10;
   localparam int S_VOK = 11;
   localparam logic [1:0] GP_OFF = 2'h0;
   localparam logic [1:0] GP_RAILS = 2'h1;
   localparam logic [1:0] GP_ECHO = 2'h2;
   localparam logic [13:0] CTRL_RST = 14'h1fff;
   localparam logic [7:0] PERIOD_RST = 8'h32;
   localparam logic [31:0] PHASE_RST = 32'h25190c00;
   localparam logic [31:0] TARGET_RST = 32'hc0c0c0c0;
   localparam logic [23:0] SS_RST = 24'h1007d0;
   localparam logic [15:0] PGDLY_RST = 16'h00c8;

   typedef enum logic [2:0]
   {
      ST_OFF = 3'h0,
      ST_DELAY = 3'h1,
      ST_RAMP = 3'h3,
      ST_STEADY = 3'h2,
      ST_HICCUP = 3'h6
   } brs_state_t;

   typedef struct packed {
      logic [AW-1:0] s1;
      logic [AW-1:0] s2;
      logic en_prev;
      logic [7:0] hold;
      logic [7:0] live;
      logic [7:0] osc;
      logic [5:0] pre;
      logic dph_v;
      logic dph_w;
      logic [7:0] dph_a;
      logic [31:0] rdata;
      logic [13:0] ctrl;
      logic [7:0] period;
      logic [31:0] phase;
      logic [31:0] target;
      logic [23:0] ss;
      logic [15:0] pgdly;
      brs_state_t [3:0] st;
      logic [3:0][15:0] tcnt;
      logic [3:0][15:0] pcnt;
      logic [3:0][6:0] ocnt;
      logic [3:0][7:0] ramp;
      logic [3:0] go;
      logic [3:0] pg;
      logic [3:0] ovd;
      logic [3:0] ovls;
      logic [3:0] tick;
      logic gpio_oe;
   } brs_regs_t;
endpackage

// *** logic/brs_supervisor.sv ***
// Supervisor for four buck rails: enable/sync, lockout, thermal, soft start,
// power good, overvoltage discharge, output discharge, hiccup, AHB-Lite regs.
// Assumes comparator levels arrive asynchronously; clk_en low freezes all.
//
// Decided for this implementation: the address map and the AHB-Lite register port.
`timescale 1ns/100ps

// What this block does
// - Run only while input is above lockout
// - Enable pin high runs, low stops
// - External clock edge aligns channel one
// - Programmed phase offsets kept while synchronised
// - Registers stay usable with enable low
// - Overtemperature stops rails, cool restarts soft start
// - Pre-bias start needs bootstrap and reference above
// - Delay, ramp reference to target, then hold
// - Good bit sets after configurable delay
// - Good bit clears after 50 us low
// - Rails-ok pin is AND of enabled goods
// - Rails-ok low at once on stop conditions
// - Over-current lowers good below 87% only
// - Filtered overvoltage starts repeated low-side discharge
// - Discharge mode ends below 114%
// - Input over 18V pauses discharge only
// - Overvoltage guard enabled per configuration
// - Output discharge only when enabled per channel
// - Clock echo: half period shifted, while enabled
// - Valley over-current blocks high-side turn-on
// - Over-current with low trip starts hiccup
module brs_supervisor
(
   input wire logic clock,
   input wire logic reset_n,
   input wire logic clk_en,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic enable_sync_input,
   input wire logic vin_above_lockout,
   input wire logic overtemp_hot,
   input wire logic vin_over_limit,
   input wire logic [3:0] bootstrap_ok,
   input wire logic [3:0] ref_above_fb,
   input wire logic [3:0] fb_above_good,
   input wire logic [3:0] fb_below_low_trip,
   input wire logic [3:0] fb_below_87,
   input wire logic [3:0] fb_above_120,
   input wire logic [3:0] fb_below_114,
   input wire logic [3:0] valley_oc,
   input wire logic [3:0] neg_limit_hit,
   output logic [3:0] stage_enable,
   output logic [3:0] high_side_block,
   output logic [3:0] low_side_force,
   output logic [3:0] discharge_on,
   output logic [3:0][7:0] ramp_ref,
   output logic [3:0] phase_tick,
   output logic gpio_o,
   output logic gpio_oe
);
   brs_pkg::brs_regs_t s_r;
   brs_pkg::brs_regs_t s_nxt;
   logic [brs_pkg::AW-1:0] a_in;
   logic [brs_pkg::AW-1:0] a;
   logic en;
   logic run;
   logic us_tick;
   logic rails_ok;
   logic echo;
   logic [3:0] on;

   assign a_in = {neg_limit_hit, valley_oc, fb_below_114, fb_above_120, fb_below_87,
                  fb_below_low_trip, fb_above_good, ref_above_fb, bootstrap_ok,
                  vin_over_limit, overtemp_hot, vin_above_lockout, enable_sync_input};
   assign a = s_r.s2;

   // Pin reads as enabled while high or toggling as a sync clock
   assign en = a[brs_pkg::A_EN] | (s_r.hold != 8'h00);
   assign run = en & a[brs_pkg::A_VOK] & ~a[brs_pkg::A_HOT];
   assign us_tick = (s_r.pre == brs_pkg::US_LAST);
   assign echo = (s_r.osc >= {1'b0, s_r.period[7:1]});

   // ----------------------------------------------------------------
   // Combinational outputs from registered state
   // ----------------------------------------------------------------
   always_comb
   begin
      for (int i = 0; i < 4; i++)
      begin
         on[i] = (s_r.st[i] == brs_pkg::ST_RAMP) || (s_r.st[i] == brs_pkg::ST_STEADY);
         stage_enable[i] = on[i] & s_r.go[i] & ~s_r.ovd[i];
         high_side_block[i] = a[brs_pkg::G_VOC + i] | s_r.ovd[i];
         low_side_force[i] = s_r.ovd[i] & s_r.ovls[i];
         discharge_on[i] = (s_r.st[i] == brs_pkg::ST_OFF)
                           & s_r.ctrl[brs_pkg::C_DIS + i];
         ramp_ref[i] = s_r.ramp[i];
      end
      // Disabled channels count as good; none enabled keeps it low
      rails_ok = run & (|s_r.ctrl[brs_pkg::C_EN +: 4])
                 & (&(s_r.pg | ~s_r.ctrl[brs_pkg::C_EN +: 4]));
   end

   assign phase_tick = s_r.tick;
   assign gpio_o = 1'b0;
   assign gpio_oe = s_r.gpio_oe;
   // Bus stalls while the block is frozen
   assign hreadyout = clk_en;
   assign hresp = 1'b0;
   assign hrdata = s_r.rdata;

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   always_comb
   begin
      logic rise;
      logic allow;
      logic bad;
      logic [7:0] off;
      logic [7:0] ra;
      rise = 1'b0;
      allow = 1'b0;
      bad = 1'b0;
      off = 8'h00;
      ra = 8'h00;
      s_nxt = s_r;
      s_nxt.s1 = a_in;
      s_nxt.s2 = s_r.s1;

      // Enable pin: level with hold-over so sync low phases do not stop
      rise = a[brs_pkg::A_EN] & ~s_r.en_prev;
      s_nxt.en_prev = a[brs_pkg::A_EN];
      if (a[brs_pkg::A_EN])
         s_nxt.hold = brs_pkg::EN_HOLD_C;
      else if (s_r.hold != 8'h00)
         s_nxt.hold = s_r.hold - 8'h01;
      if (rise)
         s_nxt.live = brs_pkg::EN_HOLD_C;
      else if (s_r.live != 8'h00)
         s_nxt.live = s_r.live - 8'h01;
      s_nxt.pre = us_tick ? 6'h00 : s_r.pre + 6'h01;

      // Internal oscillator, restarted by each external clock edge
      if (rise || s_r.osc >= s_r.period - 8'h01)
         s_nxt.osc = 8'h00;
      else
         s_nxt.osc = s_r.osc + 8'h01;
      for (int i = 0; i < 4; i++)
      begin
         // Channel one always sits on the aligned edge
         off = (i == 0) ? 8'h00 : s_r.phase[8*i +: 8];
         s_nxt.tick[i] = run & (s_r.osc == off);
      end

      // Open-drain pin: enable high means pulling low
      case (s_r.ctrl[brs_pkg::C_GPIO +: 2])
         brs_pkg::GP_RAILS: s_nxt.gpio_oe = ~rails_ok;
         brs_pkg::GP_ECHO: s_nxt.gpio_oe = ~(en & echo);
         default: s_nxt.gpio_oe = 1'b0;
      endcase

      // ----------------------------------------------------------------
      // Per-channel sequencing
      // ----------------------------------------------------------------
      for (int i = 0; i < 4; i++)
      begin
         allow = run & s_r.ctrl[brs_pkg::C_EN + i];
         case (s_r.st[i])
            brs_pkg::ST_OFF:
            begin
               s_nxt.ramp[i] = 8'h00;
               s_nxt.go[i] = 1'b0;
               s_nxt.tcnt[i] = 16'h0000;
               if (allow)
                  s_nxt.st[i] = brs_pkg::ST_DELAY;
            end
            brs_pkg::ST_DELAY:
            begin
               if (s_r.tcnt[i] < s_r.ss[15:0])
               begin
                  if (us_tick)
                     s_nxt.tcnt[i] = s_r.tcnt[i] + 16'h0001;
               end
               else if (a[brs_pkg::G_BST + i])
               begin
                  s_nxt.tcnt[i] = 16'h0000;
                  s_nxt.st[i] = brs_pkg::ST_RAMP;
               end
            end
            brs_pkg::ST_RAMP:
            begin
               // Switching held off until the ramp passes a pre-biased output
               if (a[brs_pkg::G_BST + i] & a[brs_pkg::G_RGF + i])
                  s_nxt.go[i] = 1'b1;
               if (us_tick)
               begin
                  if (s_r.tcnt[i] + 16'h0001 >= {8'h00, s_r.ss[23:16]})
                  begin
                     s_nxt.tcnt[i] = 16'h0000;
                     if (s_r.ramp[i] >= s_r.target[8*i +: 8])
                     begin
                        if (a[brs_pkg::G_VOC + i])
                           s_nxt.st[i] = brs_pkg::ST_HICCUP;
                        else
                           s_nxt.st[i] = brs_pkg::ST_STEADY;
                     end
                     else
                        s_nxt.ramp[i] = s_r.ramp[i] + 8'h01;
                  end
                  else
                     s_nxt.tcnt[i] = s_r.tcnt[i] + 16'h0001;
               end
            end
            brs_pkg::ST_STEADY:
               s_nxt.ramp[i] = s_r.target[8*i +: 8];
            brs_pkg::ST_HICCUP:
            begin
               s_nxt.ramp[i] = 8'h00;
               s_nxt.go[i] = 1'b0;
               if (us_tick)
                  s_nxt.tcnt[i] = s_r.tcnt[i] + 16'h0001;
               if (s_r.tcnt[i] >= brs_pkg::HIC_OFF_C && a[brs_pkg::G_BST + i])
               begin
                  s_nxt.tcnt[i] = 16'h0000;
                  s_nxt.st[i] = brs_pkg::ST_RAMP;
               end
            end
            default:
               s_nxt.st[i] = brs_pkg::ST_OFF;
         endcase
         // Short with over-current: power stage off, ramp restarts later
         if (on[i] && a[brs_pkg::G_VOC + i] && a[brs_pkg::G_UV + i])
         begin
            s_nxt.st[i] = brs_pkg::ST_HICCUP;
            s_nxt.ramp[i] = 8'h00;
            s_nxt.go[i] = 1'b0;
            s_nxt.tcnt[i] = 16'h0000;
         end
         if (!allow)
            s_nxt.st[i] = brs_pkg::ST_OFF;

         // Power good with rise and fall filters; overvoltage ignored
         bad = a[brs_pkg::G_UV + i]
               | (a[brs_pkg::G_VOC + i] & a[brs_pkg::G_L87 + i]);
         if (!allow || (!on[i] && !s_r.pg[i]))
         begin
            s_nxt.pg[i] = 1'b0;
            s_nxt.pcnt[i] = 16'h0000;
         end
         else if (!s_r.pg[i])
         begin
            if (!a[brs_pkg::G_PG + i])
               s_nxt.pcnt[i] = 16'h0000;
            else if (s_r.pcnt[i] >= s_r.pgdly)
            begin
               s_nxt.pg[i] = 1'b1;
               s_nxt.pcnt[i] = 16'h0000;
            end
            else if (us_tick)
               s_nxt.pcnt[i] = s_r.pcnt[i] + 16'h0001;
         end
         else
         begin
            if (!bad)
               s_nxt.pcnt[i] = 16'h0000;
            else if (s_r.pcnt[i] > brs_pkg::UV_FILT_C)
            begin
               s_nxt.pg[i] = 1'b0;
               s_nxt.pcnt[i] = 16'h0000;
            end
            else if (us_tick)
               s_nxt.pcnt[i] = s_r.pcnt[i] + 16'h0001;
         end

         // Overvoltage discharge
         if (!s_r.ctrl[brs_pkg::C_OVP + i] || !allow)
         begin
            s_nxt.ovd[i] = 1'b0;
            s_nxt.ovls[i] = 1'b0;
            s_nxt.ocnt[i] = 7'h00;
         end
         else if (!s_r.ovd[i])
         begin
            if (!a[brs_pkg::G_OV + i])
               s_nxt.ocnt[i] = 7'h00;
            else if (s_r.ocnt[i] + 7'h01 >= brs_pkg::OV_FILT_C)
            begin
               s_nxt.ovd[i] = 1'b1;
               s_nxt.ovls[i] = ~a[brs_pkg::A_VOV];
               s_nxt.ocnt[i] = 7'h00;
            end
            else
               s_nxt.ocnt[i] = s_r.ocnt[i] + 7'h01;
         end
         else if (a[brs_pkg::G_L114 + i])
         begin
            s_nxt.ovd[i] = 1'b0;
            s_nxt.ovls[i] = 1'b0;
            s_nxt.ocnt[i] = 7'h00;
         end
         else if (a[brs_pkg::A_VOV])
         begin
            // Input too high: stop switching, restart after the delay
            s_nxt.ovls[i] = 1'b0;
            s_nxt.ocnt[i] = 7'h00;
         end
         else if (s_r.ovls[i])
         begin
            if (a[brs_pkg::G_NEG + i])
            begin
               s_nxt.ovls[i] = 1'b0;
               s_nxt.ocnt[i] = 7'h00;
            end
         end
         else if (s_r.ocnt[i] + 7'h01 >= brs_pkg::OV_REP_C)
         begin
            s_nxt.ovls[i] = 1'b1;
            s_nxt.ocnt[i] = 7'h00;
         end
         else
            s_nxt.ocnt[i] = s_r.ocnt[i] + 7'h01;
      end

      // ----------------------------------------------------------------
      // AHB-Lite slave: independent of enable and lockout
      // ----------------------------------------------------------------
      if (s_r.dph_v && s_r.dph_w)
      begin
         if (s_r.dph_a == brs_pkg::A_CTRL)
            s_nxt.ctrl = hwdata[13:0];
         else if (s_r.dph_a == brs_pkg::A_PERIOD)
            s_nxt.period = hwdata[7:0];
         else if (s_r.dph_a == brs_pkg::A_PHASE)
            s_nxt.phase = hwdata;
         else if (s_r.dph_a == brs_pkg::A_TARGET)
            s_nxt.target = hwdata;
         else if (s_r.dph_a == brs_pkg::A_SS)
            s_nxt.ss = hwdata[23:0];
         else if (s_r.dph_a == brs_pkg::A_PGDLY)
            s_nxt.pgdly = hwdata[15:0];
      end
      s_nxt.dph_v = 1'b0;
      s_nxt.dph_w = 1'b0;
      if (hsel && htrans[1] && hready)
      begin
         ra = (haddr[31:8] == 24'h000000) ? haddr[7:0] : 8'hff;
         s_nxt.dph_v = 1'b1;
         s_nxt.dph_w = hwrite;
         s_nxt.dph_a = ra;
         s_nxt.rdata = 32'h00000000;
         if (ra == brs_pkg::A_CTRL)
            s_nxt.rdata = {18'h00000, s_r.ctrl};
         else if (ra == brs_pkg::A_PERIOD)
            s_nxt.rdata = {24'h000000, s_r.period};
         else if (ra == brs_pkg::A_PHASE)
            s_nxt.rdata = s_r.phase;
         else if (ra == brs_pkg::A_TARGET)
            s_nxt.rdata = s_r.target;
         else if (ra == brs_pkg::A_SS)
            s_nxt.rdata = {8'h00, s_r.ss};
         else if (ra == brs_pkg::A_PGDLY)
            s_nxt.rdata = {16'h0000, s_r.pgdly};
         else if (ra == brs_pkg::A_STATUS)
         begin
            s_nxt.rdata[brs_pkg::S_OVD +: 4] = s_r.ovd;
            s_nxt.rdata[brs_pkg::S_PG +: 4] = s_r.pg;
            s_nxt.rdata[brs_pkg::S_RUN] = run;
            s_nxt.rdata[brs_pkg::S_SYNC] = (s_r.live != 8'h00);
            s_nxt.rdata[brs_pkg::S_HOT] = a[brs_pkg::A_HOT];
            s_nxt.rdata[brs_pkg::S_VOK] = a[brs_pkg::A_VOK];
         end
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         s_r <= '0;
         s_r.ctrl <= brs_pkg::CTRL_RST;
         s_r.period <= brs_pkg::PERIOD_RST;
         s_r.phase <= brs_pkg::PHASE_RST;
         s_r.target <= brs_pkg::TARGET_RST;
         s_r.ss <= brs_pkg::SS_RST;
         s_r.pgdly <= brs_pkg::PGDLY_RST;
      end
      else if (clk_en)
         s_r <= s_nxt;
   end
endmodule

// *** dv/brs_supervisor_asserts.sv ***
// Port-level checks for the four-rail buck supervisor.
// Assumes one clock domain and clk_en held high.
`timescale 1ns/100ps
module brs_supervisor_asserts
(
   input wire logic clock,
   input wire logic reset_n,
   input wire logic enable_sync_input,
   input wire logic vin_above_lockout,
   input wire logic overtemp_hot,
   input wire logic vin_over_limit,
   input wire logic [3:0] valley_oc,
   input wire logic [3:0] neg_limit_hit,
   input wire logic [3:0] stage_enable,
   input wire logic [3:0] high_side_block,
   input wire logic [3:0] low_side_force,
   input wire logic [3:0] discharge_on
);
   // ----------------------------------------------------------------
   // Helper counters: cycles since reset, cycles with enable low
   // ----------------------------------------------------------------
   typedef struct packed {logic [2:0] up; logic [7:0] enlo;} brs_chk_t;
   brs_chk_t c_r;
   brs_chk_t c_nxt;
   always_comb
   begin
      c_nxt = c_r;
      if (c_r.up != 3'h7)
         c_nxt.up = c_r.up + 3'h1;
      if (enable_sync_input)
         c_nxt.enlo = 8'h00;
      else if (c_r.enlo != 8'hff)
         c_nxt.enlo = c_r.enlo + 8'h01;
   end
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
         c_r <= '0;
      else
         c_r <= c_nxt;
   end
   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);
   sequence s_neg_seen;
      (low_side_force[1] && neg_limit_hit[1])[*2];
   endsequence
   sequence s_lsf_off;
      !low_side_force[1];
   endsequence
   AST_LOCKOUT: assert property ((!vin_above_lockout)[*7] |-> stage_enable == 4'h0)
      else $error("stage enabled under input lockout");
   AST_HOT: assert property (overtemp_hot[*7] |-> stage_enable == 4'h0)
      else $error("stage enabled while hot");
   AST_EN_OFF: assert property (c_r.enlo >= 8'haa |-> stage_enable == 4'h0)
      else $error("stage enabled with enable pin low");
   AST_DISCH: assert property ((discharge_on & stage_enable) == 4'h0)
      else $error("discharge path on a switching channel");
   AST_VALLEY: assert property ((c_r.up == 3'h7) |->
      ((valley_oc & $past(valley_oc) & $past(valley_oc, 2) & ~high_side_block) == 4'h0))
      else $error("high side not blocked under valley current");
   AST_VIN_OV: assert property (vin_over_limit[*7] |-> low_side_force == 4'h0)
      else $error("discharge kept on above input limit");
   AST_NEG_LIM: assert property (s_neg_seen |-> ##[0:4] s_lsf_off)
      else $error("low side held past negative limit");
   AST_OV_GAP: assert property ($fell(low_side_force[1]) |-> s_lsf_off[*8])
      else $error("discharge repeated without delay");
endmodule
bind brs_supervisor brs_supervisor_asserts u_chk (.clock, .reset_n, .enable_sync_input,
   .vin_above_lockout, .overtemp_hot, .vin_over_limit, .valley_oc, .neg_limit_hit,
   .stage_enable, .high_side_block, .low_side_force, .discharge_on);

// *** dv/brs_stage_model.sv ***
// Behavioural model of four buck power stages and their comparators.
// Assumes every channel targets code TGT; bench commands faults.
`timescale 1ns/100ps
module brs_stage_model
#(
   parameter int TGT = 32
)
(
   input wire logic clock,
   input wire logic [3:0] stage_enable,
   input wire logic [3:0] low_side_force,
   input wire logic [3:0][7:0] ramp_ref,
   input wire logic [3:0] ov_cmd,
   input wire logic [3:0] short_cmd,
   output logic [3:0] ref_above_fb,
   output logic [3:0] fb_above_good,
   output logic [3:0] fb_below_low_trip,
   output logic [3:0] fb_below_87,
   output logic [3:0] fb_above_120,
   output logic [3:0] fb_below_114,
   output logic [3:0] valley_oc,
   output logic [3:0] neg_limit_hit
);
   // ----------------------------------------------------------------
   // Output levels: lag the reference by one code so it stays ahead
   // ----------------------------------------------------------------
   logic [3:0][7:0] fb = '0;
   logic [3:0] neg = '0;
   assign valley_oc = short_cmd;
   assign neg_limit_hit = neg;
   always @(posedge clock)
   begin
      neg <= low_side_force;
      for (int i = 0; i < 4; i++)
      begin
         if (short_cmd[i])
            fb[i] <= 8'h00;
         else if (ov_cmd[i])
            fb[i] <= 8'h30;
         else if (stage_enable[i])
            fb[i] <= ramp_ref[i] - 8'(ramp_ref[i] != 8'h00);
         else
            fb[i] <= fb[i] - 8'(fb[i] != 8'h00);
      end
   end
   always_comb
   begin
      for (int i = 0; i < 4; i++)
      begin
         ref_above_fb[i] = ramp_ref[i] > fb[i];
         fb_above_good[i] = int'(fb[i]) * 100 > TGT * 92;
         fb_below_low_trip[i] = int'(fb[i]) * 100 < TGT * 45;
         fb_below_87[i] = int'(fb[i]) * 100 < TGT * 87;
         fb_above_120[i] = int'(fb[i]) * 100 > TGT * 120;
         fb_below_114[i] = int'(fb[i]) * 100 < TGT * 114;
      end
   end
endmodule

// *** dv/buck_rail_supervisor_bench.sv ***
// Self-checking bench for the four-rail buck supervisor.
// Assumes the stage model on the rail side and an AHB-Lite master here.
`timescale 1ns/100ps
module buck_rail_supervisor_bench;
   logic clock = 1'b0;
   logic reset_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready, hreadyout, hresp;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
   logic enable_sync_input = 1'b0, vin_above_lockout = 1'b0;
   logic overtemp_hot = 1'b0, vin_over_limit = 1'b0, gpio_o, gpio_oe;
   logic [3:0] ov_cmd = '0, short_cmd = '0, ref_above_fb, fb_above_good, fb_below_low_trip;
   logic [3:0] fb_below_87, fb_above_120, fb_below_114, valley_oc, neg_limit_hit;
   logic [3:0] stage_enable, high_side_block, low_side_force, discharge_on, phase_tick;
   logic [3:0][7:0] ramp_ref;
   int miscompares = 0, cmp_count = 0, k, n;
   logic [39:0] rows [7] = '{40'h0000001fff, 40'h0400000032, 40'h0825190c00,
      40'h0cc0c0c0c0, 40'h10001007d0, 40'h14000000c8, 40'h1c00000000};
   assign hready = hreadyout;
   initial forever #12.5 clock = ~clock;
   brs_supervisor uut (.clock, .reset_n, .clk_en(1'b1), .hsel, .haddr, .htrans, .hwrite,
      .hsize(3'h2), .hwdata, .hready, .hreadyout, .hresp, .hrdata, .enable_sync_input,
      .vin_above_lockout, .overtemp_hot, .vin_over_limit, .bootstrap_ok(4'hf), .ref_above_fb,
      .fb_above_good, .fb_below_low_trip, .fb_below_87, .fb_above_120, .fb_below_114,
      .valley_oc, .neg_limit_hit, .stage_enable, .high_side_block, .low_side_force,
      .discharge_on, .ramp_ref, .phase_tick, .gpio_o, .gpio_oe);
   brs_stage_model #(.TGT(32)) stages (.clock, .stage_enable, .low_side_force, .ramp_ref,
      .ov_cmd, .short_cmd, .ref_above_fb, .fb_above_good, .fb_below_low_trip, .fb_below_87,
      .fb_above_120, .fb_below_114, .valley_oc, .neg_limit_hit);
   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         miscompares++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h000000, a};
      @(posedge clock);
      while (hready !== 1'b1) @(posedge clock);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge clock);
      while (hready !== 1'b1) @(posedge clock);
      rd = hrdata;
   endtask
   task automatic stop_test;
      $display("comparisons %0d miscompares %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial
   begin
      repeat (40000) @(posedge clock);
      miscompares++;
      stop_test;
   end
   initial
   begin
      repeat (16) @(posedge clock);
      reset_n <= 1'b1;
      @(posedge clock);
      bus(1'b1, 8'h1c, 32'h5a5a5a5a);
      for (int i = 0; i < 7; i++)
      begin
         bus(1'b0, rows[i][39:32], 32'h0);
         chk(rd, rows[i][31:0]);
      end
      // Short delays keep the run brief: 2 us start, 1 us per code
      bus(1'b1, 8'h10, 32'h00010002);
      bus(1'b1, 8'h14, 32'h00000004);
      bus(1'b1, 8'h0c, 32'h20202020);
      vin_above_lockout <= 1'b1;
      enable_sync_input <= 1'b1;
      for (k = 0; k < 4000 && ramp_ref[0] !== 8'h20; k++) @(posedge clock);
      repeat (400) @(posedge clock);
      chk(ramp_ref, 32'h20202020);
      chk(32'({stage_enable, gpio_oe}), 32'h1e);
      bus(1'b0, 8'h18, 32'h0);
      chk(32'(rd[7:4]), 32'hf);
      ov_cmd <= 4'h2;
      for (k = 0; k < 300 && low_side_force[1] !== 1'b1; k++) @(posedge clock);
      chk(32'(k >= 100 && k < 300), 32'h1);
      bus(1'b0, 8'h18, 32'h0);
      chk(32'({rd[1], rd[5], gpio_oe}), 32'h6);
      vin_over_limit <= 1'b1;
      repeat (10) @(posedge clock);
      chk(32'(low_side_force), 32'h0);
      vin_over_limit <= 1'b0;
      for (k = 0; k < 200 && low_side_force[1] !== 1'b1; k++) @(posedge clock);
      chk(32'(k >= 40 && k < 200), 32'h1);
      ov_cmd <= 4'h0;
      repeat (300) @(posedge clock);
      bus(1'b0, 8'h18, 32'h0);
      chk(32'(rd[3:0]), 32'h0);
      short_cmd <= 4'h4;
      repeat (8) @(posedge clock);
      chk(32'(high_side_block[2]), 32'h1);
      for (k = 0; k < 3000 && gpio_oe !== 1'b1; k++) @(posedge clock);
      chk(32'({k >= 1960 && k < 3000, stage_enable[2]}), 32'h2);
      short_cmd <= 4'h0;
      overtemp_hot <= 1'b1;
      repeat (8) @(posedge clock);
      chk(32'({stage_enable, gpio_oe}), 32'h1);
      overtemp_hot <= 1'b0;
      for (k = 0; k < 4000 && ramp_ref[0] !== 8'h20; k++) @(posedge clock);
      chk(32'(k >= 1280 && k < 4000), 32'h1);
      enable_sync_input <= 1'b0;
      repeat (200) @(posedge clock);
      chk(32'({stage_enable, discharge_on, gpio_oe}), 32'h1f);
      bus(1'b0, 8'h04, 32'h0);
      chk(rd ^ 32'({hresp, gpio_o}), 32'h32);
      bus(1'b1, 8'h00, 32'h000020ff);
      repeat (4) @(posedge clock);
      chk(32'(discharge_on), 32'h0);
      enable_sync_input <= 1'b1;
      repeat (5) @(posedge clock);
      chk(32'(phase_tick), 32'h1);
      repeat (12) @(posedge clock);
      chk(32'(phase_tick), 32'h2);
      repeat (43) @(posedge clock);
      n = 0;
      repeat (500)
      begin
         @(negedge clock);
         n += int'(gpio_oe === 1'b0);
      end
      chk(n, 250);
      vin_above_lockout <= 1'b0;
      repeat (8) @(posedge clock);
      chk(32'(stage_enable), 32'h0);
      stop_test;
   end
endmodule
